// ===== rtl/pmeic_pkg.sv
// Package: register map, field positions and reset values of the event/mask block
package pmeic_pkg;
  localparam logic [7:0] EVENT_A_ADDR = 8'h06;
  localparam logic [7:0] EVENT_B_ADDR = 8'h07;
  localparam logic [7:0] EVENT_C_ADDR = 8'h08;
  localparam logic [7:0] GPI_EVENT_FLAGS_HIGH_ADDR = 8'h09;
  localparam logic [7:0] MASK_SYSTEM_ADDR = 8'h0A;
  localparam logic [7:0] MASK_SUPPLY_ADDR = 8'h0B;
  localparam logic [7:0] MASK_INPUTS_LOW_ADDR = 8'h0C;
  localparam logic [7:0] MASK_INPUTS_HIGH_ADDR = 8'h0D;
  localparam logic [7:0] CONTROL_ADDR = 8'h0E;
  // Writable bits of the first mask and event register
  localparam logic [7:0] SYSTEM_BITS = 8'h19;
  localparam int SEQ_DONE_BIT = 4;
  localparam int ADC_READY_BIT = 3;
  localparam int BUTTON_BIT = 0;
  // Summary bits of the first event register
  localparam int SUM_D_BIT = 7;
  localparam int SUM_C_BIT = 6;
  localparam int SUM_B_BIT = 5;
  // Control register fields
  localparam int LOCK_SECOND_BIT = 6;
  localparam int LOCK_MAIN_BIT = 5;
  localparam int LOCK_SYSTEM_BIT = 4;
  localparam int STANDBY_BIT = 3;
  localparam int SECOND_TARGET_BIT = 2;
  localparam int MAIN_TARGET_BIT = 1;
  localparam int SYSTEM_TARGET_BIT = 0;
  localparam logic [7:0] CONTROL_RW_BITS = 8'h7F;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  // Input port event positions in the fourth event register
  localparam int INPUT8_BIT = 0;
  localparam int INPUT9_BIT = 1;
endpackage : pmeic_pkg

// ===== rtl/pmeic_bus_if.sv
// Interface: internal register write strobe bundle
`timescale 1ns/1ps
interface pmeic_bus_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  modport master (output wr_en, output addr, output wdata);
  modport slave (input wr_en, input addr, input wdata);
endinterface : pmeic_bus_if

// ===== rtl/pmeic_event_reg.sv
// One 8-bit event register: latch, write-back clear and one-cycle deferral of events during a clear
`timescale 1ns/1ps
module pmeic_event_reg #(
  parameter logic [7:0] ADDR = 8'h06,
  parameter logic [7:0] VALID = 8'hFF
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_hold,
  pmeic_bus_if.slave bus,
  input wire logic [7:0] i_set,
  output logic [7:0] o_flags
);
  logic [7:0] deferred;
  logic clr_hit;

  assign clr_hit = bus.wr_en && (bus.addr == ADDR);

  // Events arriving while a clear is in progress wait one cycle, then latch
  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_hold) begin
      deferred <= pmeic_pkg::EVENT_RESET;
    end else if (clr_hit) begin
      deferred <= i_set & VALID;
    end else begin
      deferred <= pmeic_pkg::EVENT_RESET;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_hold) begin
      o_flags <= pmeic_pkg::EVENT_RESET;
    end else if (clr_hit) begin
      o_flags <= (o_flags & ~bus.wdata) | deferred;
    end else begin
      o_flags <= o_flags | ((i_set | deferred) & VALID);
    end
  end
endmodule : pmeic_event_reg

// ===== rtl/pmeic_top.sv
// Event collection, interrupt masking and domain control register
`timescale 1ns/1ps
// Functional notes
// - Interrupt line stays low until every unmasked pending event is written back.
// - Writing back the read value clears each set event bit.
// - Fourth event bits 1 and 0 flag input 9 and input 8 port events.
// - First mask bits 4, 3, 0 mask sequencer, ADC and button events.
// - Second mask bits 7..0 mask the eight supply-related events.
// - Third mask bits mask inputs 7..0, bits 2..0 also ADC thresholds.
// - Fourth mask bits mask inputs 15..8 and their shared port events.
// - Control bits 6..4 of a write lock the three target bits against that same write.
// - Control bit 3 picks standby or hibernate on system domain release.
// - Control bits 2 and 1 hold second and main domain targets.
// - Any unmasked set event drives the interrupt line low.
// - Interrupt held inactive during power-up until events are cleared.
// - Events arriving during a clear are delayed, never lost.
// - Control bit 0 holds the system domain target.
module pmeic_top (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_ev_system,
  input wire logic [7:0] i_ev_supply,
  input wire logic [7:0] i_ev_inputs_low,
  input wire logic [7:0] i_ev_inputs_high,
  input wire logic i_powerup_active,
  input wire logic [2:0] i_otp_load,
  input wire logic [2:0] i_otp_targets,
  input wire logic i_system_domain_port,
  input wire logic i_main_domain_port,
  input wire logic i_second_domain_port,
  output logic o_irq_out_n,
  output logic o_system_target,
  output logic o_main_target,
  output logic o_second_target,
  output logic o_standby_select
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] port_meta;
  logic [2:0] port_sync;
  logic [2:0] port_prev;
  logic [2:0] port_edge;

  // Enable ports are asynchronous pins: two flops before any logic reads them
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      port_meta <= 3'h0;
      port_sync <= 3'h0;
    end else begin
      port_meta <= {i_second_domain_port, i_main_domain_port, i_system_domain_port};
      port_sync <= port_meta;
    end
  end

  // Edge history reads only the second flop
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      port_prev <= 3'h0;
    end else begin
      port_prev <= port_sync;
    end
  end

  // Both edges count: any level change on a port is an event
  assign port_edge = port_sync ^ port_prev;

  // ----------------------------------------------------------------
  // Internal write bus
  // ----------------------------------------------------------------
  pmeic_bus_if bus ();
  assign bus.wr_en = i_reg_wr;
  assign bus.addr = i_reg_addr;
  assign bus.wdata = i_reg_wdata;

  // ----------------------------------------------------------------
  // Event registers
  // ----------------------------------------------------------------
  logic [7:0] flags_system;
  logic [7:0] flags_supply;
  logic [7:0] flags_inputs_low;
  logic [7:0] gpi_event_flags_high;
  logic [7:0] set_inputs_high;

  // Port activity shares the input 8/9/10 event bits
  always_comb begin
    set_inputs_high = i_ev_inputs_high;
    set_inputs_high[pmeic_pkg::INPUT8_BIT] |= port_edge[0];
    set_inputs_high[pmeic_pkg::INPUT9_BIT] |= port_edge[1];
    // The second domain port shares the input 10 bit, just above input 9
    set_inputs_high[pmeic_pkg::INPUT9_BIT + 1] |= port_edge[2];
  end

  pmeic_event_reg #(
    .ADDR(pmeic_pkg::EVENT_A_ADDR),
    .VALID(pmeic_pkg::SYSTEM_BITS)
  ) u_ev_system (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_hold(i_powerup_active),
    .bus(bus),
    .i_set(i_ev_system),
    .o_flags(flags_system)
  );

  pmeic_event_reg #(
    .ADDR(pmeic_pkg::EVENT_B_ADDR),
    .VALID(8'hFF)
  ) u_ev_supply (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_hold(i_powerup_active),
    .bus(bus),
    .i_set(i_ev_supply),
    .o_flags(flags_supply)
  );

  pmeic_event_reg #(
    .ADDR(pmeic_pkg::EVENT_C_ADDR),
    .VALID(8'hFF)
  ) u_ev_inputs_low (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_hold(i_powerup_active),
    .bus(bus),
    .i_set(i_ev_inputs_low),
    .o_flags(flags_inputs_low)
  );

  pmeic_event_reg #(
    .ADDR(pmeic_pkg::GPI_EVENT_FLAGS_HIGH_ADDR),
    .VALID(8'hFF)
  ) u_ev_inputs_high (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_hold(i_powerup_active),
    .bus(bus),
    .i_set(set_inputs_high),
    .o_flags(gpi_event_flags_high)
  );

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  logic [7:0] irq_mask_system;
  logic [7:0] irq_mask_supply;
  logic [7:0] irq_mask_inputs_low;
  logic [7:0] irq_mask_inputs_high;

  // Reserved bits of the first mask never store a one
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      irq_mask_system <= pmeic_pkg::MASK_RESET;
    end else if (i_reg_wr && (i_reg_addr == pmeic_pkg::MASK_SYSTEM_ADDR)) begin
      irq_mask_system <= i_reg_wdata & pmeic_pkg::SYSTEM_BITS;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      irq_mask_supply <= pmeic_pkg::MASK_RESET;
    end else if (i_reg_wr && (i_reg_addr == pmeic_pkg::MASK_SUPPLY_ADDR)) begin
      irq_mask_supply <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      irq_mask_inputs_low <= pmeic_pkg::MASK_RESET;
    end else if (i_reg_wr && (i_reg_addr == pmeic_pkg::MASK_INPUTS_LOW_ADDR)) begin
      irq_mask_inputs_low <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      irq_mask_inputs_high <= pmeic_pkg::MASK_RESET;
    end else if (i_reg_wr && (i_reg_addr == pmeic_pkg::MASK_INPUTS_HIGH_ADDR)) begin
      irq_mask_inputs_high <= i_reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------
  logic [3:0] pending_by_reg;
  logic unmasked_pending;

  // A mask gates only the line; the flag itself keeps latching
  assign pending_by_reg[0] = |(flags_system & ~irq_mask_system);
  assign pending_by_reg[1] = |(flags_supply & ~irq_mask_supply);
  assign pending_by_reg[2] = |(flags_inputs_low & ~irq_mask_inputs_low);
  assign pending_by_reg[3] = |(gpi_event_flags_high & ~irq_mask_inputs_high);
  assign unmasked_pending = |pending_by_reg;

  // Line is forced inactive through power-up, while the flags are cleared
  always_ff @(posedge i_core_clk) begin
    if (i_srst || i_powerup_active) begin
      o_irq_out_n <= 1'b1;
    end else begin
      o_irq_out_n <= ~unmasked_pending;
    end
  end

  // ----------------------------------------------------------------
  // Domain control register
  // ----------------------------------------------------------------
  logic [7:0] power_domain_control;
  logic [7:0] next_control;
  logic [2:0] target_lock;

  // Lock bits act on the data of the same write, not on the stored value
  assign target_lock = i_reg_wdata[pmeic_pkg::LOCK_SECOND_BIT:pmeic_pkg::LOCK_SYSTEM_BIT];

  always_comb begin
    next_control = power_domain_control;
    if (i_reg_wr && (i_reg_addr == pmeic_pkg::CONTROL_ADDR)) begin
      next_control[pmeic_pkg::LOCK_SECOND_BIT:pmeic_pkg::STANDBY_BIT] =
        i_reg_wdata[pmeic_pkg::LOCK_SECOND_BIT:pmeic_pkg::STANDBY_BIT];
      for (int k = 0; k < 3; k++) begin
        if (!target_lock[k]) begin
          next_control[k] = i_reg_wdata[k];
        end
      end
    end
    // One-time defaults and the enable ports override the stored targets
    for (int k = 0; k < 3; k++) begin
      if (i_otp_load[k]) begin
        next_control[k] = i_otp_targets[k];
      end else if (port_edge[k]) begin
        next_control[k] = port_sync[k];
      end
    end
    next_control = next_control & pmeic_pkg::CONTROL_RW_BITS;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      power_domain_control <= pmeic_pkg::CONTROL_RESET;
    end else begin
      power_domain_control <= next_control;
    end
  end

  // Outputs load the next value so they change on the same edge as the register
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_system_target <= 1'b0;
      o_main_target <= 1'b0;
      o_second_target <= 1'b0;
      o_standby_select <= 1'b0;
    end else begin
      o_system_target <= next_control[pmeic_pkg::SYSTEM_TARGET_BIT];
      o_main_target <= next_control[pmeic_pkg::MAIN_TARGET_BIT];
      o_second_target <= next_control[pmeic_pkg::SECOND_TARGET_BIT];
      o_standby_select <= next_control[pmeic_pkg::STANDBY_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] read_mux;
  logic [7:0] summary_bits;

  always_comb begin
    summary_bits = 8'h00;
    summary_bits[pmeic_pkg::SUM_D_BIT] =
      |(flags_supply | flags_inputs_low | gpi_event_flags_high);
    summary_bits[pmeic_pkg::SUM_C_BIT] = |(flags_supply | flags_inputs_low);
    summary_bits[pmeic_pkg::SUM_B_BIT] = |flags_supply;
  end

  // Unmapped addresses read as zero
  always_comb begin
    case (i_reg_addr)
      pmeic_pkg::EVENT_A_ADDR: read_mux = summary_bits | flags_system;
      pmeic_pkg::EVENT_B_ADDR: read_mux = flags_supply;
      pmeic_pkg::EVENT_C_ADDR: read_mux = flags_inputs_low;
      pmeic_pkg::GPI_EVENT_FLAGS_HIGH_ADDR: read_mux = gpi_event_flags_high;
      pmeic_pkg::MASK_SYSTEM_ADDR: read_mux = irq_mask_system;
      pmeic_pkg::MASK_SUPPLY_ADDR: read_mux = irq_mask_supply;
      pmeic_pkg::MASK_INPUTS_LOW_ADDR: read_mux = irq_mask_inputs_low;
      pmeic_pkg::MASK_INPUTS_HIGH_ADDR: read_mux = irq_mask_inputs_high;
      pmeic_pkg::CONTROL_ADDR: read_mux = power_domain_control;
      default: read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= read_mux;
    end
  end
endmodule : pmeic_top

// ===== sim/pmeic_chk.sv
// Checker: interrupt line and control register relations at the block ports
`timescale 1ns/1ps
module pmeic_chk (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_ev_supply,
  input wire logic i_powerup_active,
  input wire logic [2:0] i_otp_load,
  input wire logic [2:0] i_otp_targets,
  input wire logic o_irq_out_n,
  input wire logic o_system_target,
  input wire logic o_main_target,
  input wire logic o_standby_select
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  logic [7:0] mask_b;
  logic wr_ctl;
  // Shadow of the supply mask, so unmasked events can be told apart
  always_ff @(posedge i_core_clk) begin
    if (i_srst) mask_b <= 8'h00;
    else if (i_reg_wr && i_reg_addr == 8'h0B) mask_b <= i_reg_wdata;
  end
  assign wr_ctl = i_reg_wr && i_reg_addr == 8'h0E && i_otp_load == 3'h0;
  a_powerup_quiet: assert property (i_powerup_active |=> o_irq_out_n)
    else $error("irq active during power-up");
  a_event_drives_irq: assert property (
    ((i_ev_supply & ~mask_b) != 8'h00) && !i_powerup_active |-> ##[2:3] !o_irq_out_n)
    else $error("unmasked event did not assert irq");
  a_irq_held_low: assert property (!o_irq_out_n && !i_reg_wr && !$past(i_reg_wr)
    && !i_powerup_active && !$past(i_powerup_active) |=> !o_irq_out_n)
    else $error("irq released without write-back");
  a_lock_system: assert property (wr_ctl && i_reg_wdata[4] |=> $stable(o_system_target))
    else $error("locked system target changed");
  a_write_main: assert property (wr_ctl && !i_reg_wdata[5]
    |=> o_main_target == $past(i_reg_wdata[1])) else $error("main target not written");
  a_write_system: assert property (wr_ctl && !i_reg_wdata[4]
    |=> o_system_target == $past(i_reg_wdata[0])) else $error("system target wrong");
  a_standby_select: assert property (i_reg_wr && i_reg_addr == 8'h0E
    |=> o_standby_select == $past(i_reg_wdata[3])) else $error("standby select wrong");
  a_otp_main: assert property (i_otp_load[1] |=> o_main_target == $past(i_otp_targets[1]))
    else $error("main target not loaded");
  a_mask_reserved: assert property (i_reg_rd && i_reg_addr == 8'h0A
    |=> (o_reg_rdata & 8'hE6) == 8'h00) else $error("reserved mask bits read set");
endmodule // pmeic_chk
bind pmeic_top pmeic_chk u_chk (.i_core_clk, .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
  .i_reg_wdata, .o_reg_rdata, .i_ev_supply, .i_powerup_active, .i_otp_load, .i_otp_targets,
  .o_irq_out_n, .o_system_target, .o_main_target, .o_standby_select);

// ===== sim/pmeic_host.sv
// Host model: register read, write and event write-back over the access strobes
`timescale 1ns/1ps
module pmeic_host (
  input wire logic i_core_clk,
  input wire logic [7:0] i_reg_rdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // Idle address and data show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_core_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_core_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    @(negedge i_core_clk);
    d = i_reg_rdata;
  endtask
  task automatic ack(input logic [7:0] a);
    logic [7:0] v;
    rd(a, v);
    wr(a, v);
  endtask
endmodule // pmeic_host

// ===== sim/tb.sv
// Testbench: register sequences for event latching, masking and domain control
`timescale 1ns/1ps
module tb;
  logic clk, srst, pwr, sys_p, main_p, sec_p, wr, rd, irq_n, t_sys, t_main, t_sec, stby;
  logic [7:0] ev [4];
  logic [2:0] oload, otgt;
  logic [7:0] addr, wdata, rdata, v;
  int fail_count, checks;
  localparam logic [7:0] VALID [4] = '{8'h19, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] CW [5] = '{8'h0F, 8'h70, 8'h20, 8'h15, 8'h80};
  localparam logic [7:0] CE [5] = '{8'h0F, 8'h77, 8'h22, 8'h14, 8'h00};
  pmeic_top DUT (.i_core_clk(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_ev_system(ev[0]),
    .i_ev_supply(ev[1]), .i_ev_inputs_low(ev[2]), .i_ev_inputs_high(ev[3]),
    .i_powerup_active(pwr), .i_otp_load(oload), .i_otp_targets(otgt),
    .i_system_domain_port(sys_p), .i_main_domain_port(main_p), .i_second_domain_port(sec_p),
    .o_irq_out_n(irq_n), .o_system_target(t_sys), .o_main_target(t_main),
    .o_second_target(t_sec), .o_standby_select(stby));
  pmeic_host host (.i_core_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_addr(addr), .o_reg_wdata(wdata));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One-cycle event pulse, then wait until the line has been registered
  task automatic pulse(input int r, input logic [7:0] b);
    @(negedge clk);
    ev[r] = b;
    @(negedge clk);
    ev[r] = 8'h00;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #200us;
    fail_count++;
    end_sim();
  end
  initial begin
    {srst, pwr, sys_p, main_p, sec_p, oload, otgt} = {5'h10, 6'h00};
    ev = '{default: 8'h00};
    repeat (20) @(negedge clk);
    srst = 1'b0;
    for (int a = 6; a <= 15; a++) begin
      host.rd(8'(a), v);
      chk("reset value", v, 8'h00);
    end
    host.wr(8'h20, 8'hFF);
    host.rd(8'h20, v);
    chk("unmapped", v, 8'h00);
    chk("irq after reset", {7'h00, irq_n}, 8'h01);
    host.wr(8'h0A, 8'hFF);
    host.rd(8'h0A, v);
    chk("mask reserved", v, 8'h19);
    $display("test reset done");
    for (int r = 0; r < 4; r++) for (int b = 0; b < 8; b++) if (VALID[r][b]) begin
      host.wr(8'(8'h0A + r), 8'(1 << b));
      host.rd(8'(8'h0A + r), v);
      chk("mask value", v, 8'(1 << b));
      pulse(r, 8'(1 << b));
      chk("masked irq", {7'h00, irq_n}, 8'h01);
      host.rd(8'(8'h06 + r), v);
      chk("masked event latched", v, 8'(1 << b));
      host.wr(8'(8'h0A + r), 8'h00);
      repeat (2) @(negedge clk);
      chk("unmasked irq", {7'h00, irq_n}, 8'h00);
      host.wr(8'(8'h06 + r), v);
      repeat (2) @(negedge clk);
      chk("written back irq", {7'h00, irq_n}, 8'h01);
    end
    $display("test masks done");
    pulse(1, 8'h08);
    pulse(3, 8'h02);
    host.rd(8'h06, v);
    chk("summary", v, 8'hE0);
    host.ack(8'h07);
    repeat (2) @(negedge clk);
    chk("one reg pending", {7'h00, irq_n}, 8'h00);
    host.rd(8'h09, v);
    chk("input9 event", v, 8'h02);
    host.wr(8'h09, v);
    repeat (2) @(negedge clk);
    chk("all cleared", {7'h00, irq_n}, 8'h01);
    pulse(1, 8'h01);
    fork
      host.wr(8'h07, 8'h01);
      begin
        @(negedge clk);
        ev[1] = 8'h01;
        @(negedge clk);
        ev[1] = 8'h00;
      end
    join
    repeat (2) @(negedge clk);
    host.rd(8'h07, v);
    chk("event during clear", v, 8'h01);
    host.ack(8'h07);
    $display("test clearing done");
    pulse(1, 8'h04);
    pwr = 1'b1;
    repeat (2) @(negedge clk);
    chk("power-up irq", {7'h00, irq_n}, 8'h01);
    pwr = 1'b0;
    host.rd(8'h07, v);
    chk("power-up events", v, 8'h00);
    $display("test power-up done");
    for (int i = 0; i < 5; i++) begin
      host.wr(8'h0E, CW[i]);
      host.rd(8'h0E, v);
      chk("control", v, CE[i]);
      chk("targets", {4'h0, stby, t_sec, t_main, t_sys}, {4'h0, CE[i][3:0]});
    end
    @(negedge clk);
    {oload, otgt} = 6'h3D;
    @(negedge clk);
    oload = 3'h0;
    host.rd(8'h0E, v);
    chk("loaded targets", v, 8'h05);
    main_p = 1'b1;
    repeat (6) @(negedge clk);
    chk("port target", {5'h00, t_sec, t_main, t_sys}, 8'h07);
    chk("port irq", {7'h00, irq_n}, 8'h00);
    host.rd(8'h09, v);
    chk("port event", v, 8'h02);
    host.wr(8'h09, v);
    host.wr(8'h0D, 8'h07);
    host.wr(8'h0E, 8'h00);
    {sys_p, main_p, sec_p} = 3'h5;
    repeat (6) @(negedge clk);
    chk("port targets", {5'h00, t_sec, t_main, t_sys}, 8'h05);
    chk("masked port irq", {7'h00, irq_n}, 8'h01);
    host.rd(8'h09, v);
    chk("port events", v, 8'h07);
    $display("test control done");
    end_sim();
  end
endmodule // tb
